/* File: logic/bus_data_pkg.sv */
package bus_data_pkg;

    // ------------------------------------------------------------------
    // Widths and constants
    // ------------------------------------------------------------------
    localparam int unsigned DATA_W      = 64;
    localparam int unsigned VID_W       = 4;
    localparam int unsigned BEATS_W     = 3;
    localparam logic        PIN_ASSERT  = 1'b0;
    localparam logic        PIN_IDLE    = 1'b1;
    localparam logic [3:0]  VID_NO_CORE = 4'hf;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              last;
    } beat_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              valid;
    } rx_beat_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ  = 2'b01,
        ST_DATA = 2'b11,
        ST_END  = 2'b10
    } drv_state_t;

endpackage : bus_data_pkg

/* File: logic/bus_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module bus_pin_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clock,
    input  wire logic         rst_sync_n,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // ------------------------------------------------------------------
    // Two-stage synchroniser, idle high
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            meta_r <= {W{1'b1}};
            sync_r <= {W{1'b1}};
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
        end
    end

    assign pin_out = sync_r;

endmodule : bus_pin_sync

`default_nettype wire

/* File: logic/bus_data_agent.sv */
// Behaviour
// - Bus request output drives the shared request line zero.
// - Request pin sampled on reset release becomes the agent identity.
// - After configuration, request asserted whenever bus ownership is needed.
// - Presence indicator held low constantly.
// - Data path is 64 bits on shared lines driven or received.
// - Driver asserts busy while using data bus; wait for busy release.
// - Data-valid strobe asserted on every clock with valid data.
// - Driver may insert idle clocks; receivers ignore unstrobed clocks.
`timescale 1ns/1ps
`default_nettype none

module bus_data_agent (
    input  wire logic                                clock,
    input  wire logic                                rst_n,
    input  wire logic                                bus_request_out_in,
    output logic                                     bus_request_out,
    output logic                                     bus_request_out_oe,
    output logic                                     presence_indicator,
    input  wire logic [bus_data_pkg::DATA_W-1:0]     data_in_n,
    output logic      [bus_data_pkg::DATA_W-1:0]     data_out_n,
    output logic                                     data_oe,
    input  wire logic                                data_bus_busy_in,
    output logic                                     data_bus_busy_out,
    output logic                                     data_bus_busy_oe,
    input  wire logic                                data_valid_strobe_in,
    output logic                                     data_valid_strobe_out,
    output logic                                     data_valid_strobe_oe,
    input  wire logic                                defer_n,
    input  wire logic                                bus_grant,
    input  wire logic                                tx_valid,
    input  wire bus_data_pkg::beat_t                 tx_beat,
    output logic                                     tx_ready,
    output bus_data_pkg::rx_beat_t                   rx_beat,
    output logic                                     agent_id,
    output logic                                     config_done,
    output logic                                     deferred
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_r;
    logic rst_sync_n;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    localparam int unsigned SYNC_W = bus_data_pkg::DATA_W + 4;

    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_s;
    logic [bus_data_pkg::DATA_W-1:0] data_s_n;
    logic req_s_n;
    logic busy_s_n;
    logic strobe_s_n;
    logic defer_s_n;

    assign pins_raw = {data_in_n, bus_request_out_in, data_bus_busy_in,
                       data_valid_strobe_in, defer_n};

    bus_pin_sync #(
        .W (SYNC_W)
    ) u_sync (
        .clock      (clock),
        .rst_sync_n (rst_n),
        .pin_in     (pins_raw),
        .pin_out    (pins_s)
    );

    assign data_s_n   = pins_s[SYNC_W-1:4];
    assign req_s_n    = pins_s[3];
    assign busy_s_n   = pins_s[2];
    assign strobe_s_n = pins_s[1];
    assign defer_s_n  = pins_s[0];

    function automatic logic asserted(input logic pin);
        asserted = (pin == bus_data_pkg::PIN_ASSERT);
    endfunction : asserted

    // ------------------------------------------------------------------
    // Identity capture
    // ------------------------------------------------------------------
    logic id_r;
    logic id_nxt;
    logic cfg_r;
    logic cfg_nxt;

    always_comb begin
        id_nxt  = id_r;
        cfg_nxt = cfg_r;
        if (!cfg_r) begin
            id_nxt  = asserted(req_s_n);
            cfg_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            id_r  <= 1'b0;
            cfg_r <= 1'b0;
        end else begin
            id_r  <= id_nxt;
            cfg_r <= cfg_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Data driver
    // ------------------------------------------------------------------
    bus_data_pkg::drv_state_t st_r;
    bus_data_pkg::drv_state_t st_nxt;
    logic [bus_data_pkg::DATA_W-1:0] dout_r;
    logic [bus_data_pkg::DATA_W-1:0] dout_nxt;
    logic strobe_r;
    logic strobe_nxt;
    logic busy_r;
    logic busy_nxt;
    logic req_r;
    logic req_nxt;
    logic bus_free;

    assign bus_free = !asserted(busy_s_n);
    assign tx_ready = (st_r == bus_data_pkg::ST_DATA);

    always_comb begin
        st_nxt     = st_r;
        dout_nxt   = dout_r;
        strobe_nxt = 1'b0;
        busy_nxt   = busy_r;
        req_nxt    = req_r;
        case (st_r)
            bus_data_pkg::ST_IDLE: begin
                if (cfg_r && tx_valid) begin
                    req_nxt = 1'b1;
                    st_nxt  = bus_data_pkg::ST_REQ;
                end
            end
            bus_data_pkg::ST_REQ: begin
                if (bus_grant && bus_free) begin
                    req_nxt  = 1'b0;
                    busy_nxt = 1'b1;
                    st_nxt   = bus_data_pkg::ST_DATA;
                end
            end
            bus_data_pkg::ST_DATA: begin
                if (tx_valid) begin
                    dout_nxt   = tx_beat.data;
                    strobe_nxt = 1'b1;
                    if (tx_beat.last) begin
                        st_nxt = bus_data_pkg::ST_END;
                    end
                end
                // No beat offered: idle clock without strobe
            end
            bus_data_pkg::ST_END: begin
                busy_nxt = 1'b0;
                st_nxt   = bus_data_pkg::ST_IDLE;
            end
            default: begin
                st_nxt   = bus_data_pkg::ST_IDLE;
                busy_nxt = 1'b0;
                req_nxt  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_r     <= bus_data_pkg::ST_IDLE;
            dout_r   <= '0;
            strobe_r <= 1'b0;
            busy_r   <= 1'b0;
            req_r    <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            dout_r   <= dout_nxt;
            strobe_r <= strobe_nxt;
            busy_r   <= busy_nxt;
            req_r    <= req_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Receiver and defer
    // ------------------------------------------------------------------
    bus_data_pkg::rx_beat_t rx_r;
    bus_data_pkg::rx_beat_t rx_nxt;
    logic defer_r;
    logic defer_nxt;
    logic [1:0] own_d_r;
    logic [1:0] own_d_nxt;

    // Own strobe comes back through the synchroniser two clocks late
    always_comb begin
        rx_nxt       = rx_r;
        rx_nxt.valid = 1'b0;
        defer_nxt    = asserted(defer_s_n);
        own_d_nxt    = {own_d_r[0], busy_r};
        if (!own_d_r[1] && asserted(strobe_s_n)) begin
            rx_nxt.data  = ~data_s_n;
            rx_nxt.valid = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rx_r    <= '0;
            defer_r <= 1'b0;
            own_d_r <= 2'h0;
        end else begin
            rx_r    <= rx_nxt;
            defer_r <= defer_nxt;
            own_d_r <= own_d_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    assign bus_request_out       = bus_data_pkg::PIN_ASSERT;
    assign bus_request_out_oe    = req_r;
    assign presence_indicator    = bus_data_pkg::PIN_ASSERT;
    assign data_out_n            = ~dout_r;
    assign data_oe               = busy_r;
    assign data_bus_busy_out     = bus_data_pkg::PIN_ASSERT;
    assign data_bus_busy_oe      = busy_r;
    assign data_valid_strobe_out = strobe_r ? bus_data_pkg::PIN_ASSERT
                                            : bus_data_pkg::PIN_IDLE;
    assign data_valid_strobe_oe  = busy_r;
    assign rx_beat               = rx_r;
    assign agent_id              = id_r;
    assign config_done           = cfg_r;
    assign deferred              = defer_r;

endmodule : bus_data_agent

`default_nettype wire

/* File: verification/bus_data_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_data_checker (
    input wire logic                   clock,
    input wire logic                   rst_n,
    input wire logic                   bus_request_out,
    input wire logic                   bus_request_out_oe,
    input wire logic [63:0]            data_in_n,
    input wire logic [63:0]            data_out_n,
    input wire logic                   data_oe,
    input wire logic                   data_bus_busy_oe,
    input wire logic                   data_valid_strobe_in,
    input wire logic                   data_valid_strobe_out,
    input wire logic                   data_valid_strobe_oe,
    input wire logic                   defer_n,
    input wire logic                   bus_grant,
    input wire logic                   tx_valid,
    input wire bus_data_pkg::beat_t    tx_beat,
    input wire logic                   tx_ready,
    input wire bus_data_pkg::rx_beat_t rx_beat,
    input wire logic                   config_done,
    input wire logic                   deferred
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence beat_taken; tx_valid && tx_ready; endsequence
    sequence beat_last; tx_valid && tx_ready && tx_beat.last; endsequence
    sequence rx_seen; !data_valid_strobe_in && !data_valid_strobe_oe; endsequence
    a_req_after_id: assert property (
        bus_request_out_oe |-> !bus_request_out && config_done) else $error("early request");
    a_req_on_need: assert property (
        config_done && tx_valid && !bus_request_out_oe && !data_bus_busy_oe
        |-> ##[1:2] bus_request_out_oe) else $error("no request");
    a_busy_after_grant: assert property (
        $rose(data_bus_busy_oe) |-> $past(bus_grant)) else $error("busy without grant");
    a_beat_on_wire: assert property (beat_taken |=> data_oe && data_valid_strobe_oe
        && !data_valid_strobe_out && data_out_n == ~$past(tx_beat.data)) else $error("beat lost");
    a_gap_idle: assert property (
        !(tx_valid && tx_ready) |=> data_valid_strobe_out) else $error("stray strobe");
    a_busy_to_last: assert property (
        beat_last |=> data_bus_busy_oe ##1 !data_bus_busy_oe) else $error("busy release");
    a_rx_capture: assert property (rx_seen |-> ##3 rx_beat.valid
        && rx_beat.data == ~$past(data_in_n, 3)) else $error("rx beat wrong");
    a_defer_seen: assert property (
        !defer_n [*6] |-> deferred) else $error("defer missed");
endmodule : bus_data_checker
bind bus_data_agent bus_data_checker chk_u (.*);
`default_nettype wire

/* File: verification/central_agent_model.sv */
`timescale 1ns/1ps
`default_nettype none
module central_agent_model (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        id_assert,
    input  wire logic        slow,
    input  wire logic        req_line,
    output logic             req_drv_n,
    output logic             grant,
    output logic             busy_n,
    output logic             strobe_n,
    output logic [63:0]      data_n
);
    int rel_cnt;
    int wait_cnt;
    // Request line zero held low across reset release while id_assert is set
    always @(posedge clock or negedge rst_n)
        if (!rst_n) rel_cnt <= 0;
        else if (rel_cnt < 8) rel_cnt <= rel_cnt + 1;
    assign req_drv_n = !(id_assert && rel_cnt < 4);
    always @(posedge clock) wait_cnt <= req_line ? 0 : wait_cnt + 1;
    // Grant follows the request; the agent itself waits for busy release
    assign grant = !req_line && (!slow || wait_cnt >= 4);
    initial begin
        busy_n = 1'b1;
        strobe_n = 1'b1;
        data_n = '1;
    end
    task automatic send(input logic [63:0] base, input int n);
        busy_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            strobe_n = 1'b0;
            data_n = ~(base + 64'(i));
            @(posedge clock);
            #1;
            strobe_n = 1'b1;
            data_n = '1;
            @(posedge clock);
            #1;
        end
        busy_n = 1'b1;
    endtask : send
endmodule : central_agent_model
`default_nettype wire

/* File: verification/bus_data_agent_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_data_agent_tb;
    localparam logic [63:0] BASE = 64'h00ff_a5a5_0f0f_3c00;
    logic clock = 0, rst_n = 0, id_cfg = 1, slow = 0, defer_n = 1, tx_valid = 0;
    logic ro, roe, pres, doe, bo, boe, so, soe, grant, tx_ready, aid, cfg, dfr;
    logic pm_req_n, pm_busy_n, pm_strobe_n;
    logic [63:0] dout, pm_data_n, q[$], r[$];
    bus_data_pkg::beat_t tx_beat = '0;
    bus_data_pkg::rx_beat_t rx_beat;
    int n_fail = 0, check_count = 0, cyc = 0, n_overlap = 0;
    wire logic req_line = (roe ? ro : 1'b1) & pm_req_n;
    wire logic busy_line = (boe ? bo : 1'b1) & pm_busy_n;
    wire logic strobe_line = (soe ? so : 1'b1) & pm_strobe_n;
    wire logic [63:0] data_line = (doe ? dout : '1) & pm_data_n;
    bus_data_agent dut_u (.clock, .rst_n, .bus_request_out_in(req_line),
        .bus_request_out(ro), .bus_request_out_oe(roe), .presence_indicator(pres),
        .data_in_n(data_line), .data_out_n(dout), .data_oe(doe),
        .data_bus_busy_in(busy_line), .data_bus_busy_out(bo), .data_bus_busy_oe(boe),
        .data_valid_strobe_in(strobe_line), .data_valid_strobe_out(so),
        .data_valid_strobe_oe(soe), .defer_n, .bus_grant(grant), .tx_valid, .tx_beat,
        .tx_ready, .rx_beat, .agent_id(aid), .config_done(cfg), .deferred(dfr));
    central_agent_model pm_u (.clock, .rst_n, .id_assert(id_cfg), .slow, .req_line,
        .req_drv_n(pm_req_n), .grant, .busy_n(pm_busy_n), .strobe_n(pm_strobe_n),
        .data_n(pm_data_n));
    initial forever #2.5 clock = ~clock;
    always @(negedge clock) begin
        cyc++;
        if (!strobe_line && soe) q.push_back(~data_line);
        if (rx_beat.valid === 1'b1) r.push_back(rx_beat.data);
        if (boe && !pm_busy_n) n_overlap++;
        if (cyc > 4000) begin
            n_fail++;
            results();
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic do_reset(input logic id);
        rst_n = 0;
        id_cfg = id;
        tick(16);
        rst_n = 1;
        tick(8);
        check(64'(cfg), 64'h1);
        check(64'(aid), 64'(id));
        check(64'(pres), 64'h0);
        check(64'(!pres && 4'h5 != bus_data_pkg::VID_NO_CORE), 64'h1);
    endtask : do_reset
    task automatic tx_burst(input logic sl);
        int n;
        slow = sl;
        q = {};
        r = {};
        for (int k = 0; k < 3; k++) begin
            tx_valid = 1;
            tx_beat = '{data: BASE + 64'(k), last: k == 2};
            n = 0;
            while (tx_ready !== 1'b1 && n < 40) begin
                tick(1);
                n++;
            end
            tick(1);
            if (k != 1) tx_valid = 0;
            if (k == 0) tick(1);
        end
        tick(8);
        check(64'(q.size()), 64'h3);
        for (int k = 0; k < 3; k++) check(q[k], BASE + 64'(k));
        check(64'(r.size()), 64'h0);
        check(64'(boe), 64'h0);
    endtask : tx_burst
    task automatic rx_burst;
        r = {};
        pm_u.send(~BASE, 3);
        tick(6);
        check(64'(r.size()), 64'h3);
        for (int k = 0; k < 3; k++) check(r[k], ~BASE + 64'(k));
    endtask : rx_burst
    task automatic defer_seen;
        defer_n = 0;
        tick(6);
        check(64'(dfr), 64'h1);
        defer_n = 1;
        tick(6);
        check(64'(dfr), 64'h0);
    endtask : defer_seen
    task automatic busy_wait;
        int n;
        slow = 0;
        n_overlap = 0;
        q = {};
        r = {};
        n = 0;
        fork
            pm_u.send(~BASE, 2);
            begin
                tick(1);
                tx_valid = 1;
                tx_beat = '{data: BASE, last: 1'b1};
                while (tx_ready !== 1'b1 && n < 40) begin
                    tick(1);
                    n++;
                end
                tick(1);
                tx_valid = 0;
            end
        join
        tick(8);
        check(64'(n_overlap), 64'h0);
        check(64'(q.size()), 64'h1);
        check(q[0], BASE);
        check(64'(r.size()), 64'h2);
        for (int k = 0; k < 2; k++) check(r[k], ~BASE + 64'(k));
    endtask : busy_wait
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    initial begin
        do_reset(1);
        tx_burst(0);
        tx_burst(1);
        rx_burst();
        busy_wait();
        defer_seen();
        do_reset(0);
        tx_burst(0);
        results();
    end
endmodule : bus_data_agent_tb
`default_nettype wire
